// ### common/uvr_pkg.sv
// Package for the result readback bank of the UV sensor.
// Assumes a byte-wide register port driven by an I2C front end.
package uvr_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0]  ADDR_STATUS      = 8'h00;
    localparam logic [7:0]  ADDR_TEMP        = 8'h01;
    localparam logic [7:0]  ADDR_MRES1       = 8'h02;
    localparam logic [7:0]  ADDR_MRES2       = 8'h03;
    localparam logic [7:0]  ADDR_MRES3       = 8'h04;
    localparam logic [7:0]  ADDR_CONV        = 8'h05;
    localparam logic [15:0] RESULT_RESET     = 16'h0000;
    localparam logic [15:0] RESULT_MAX       = 16'hFFFF;
    localparam logic [3:0]  TEMP_PAD         = 4'h0;
    localparam int          TEMP_BITS        = 12;
    localparam int          CONV_BITS        = 24;
    localparam logic [23:0] TEMP_MIN_CLOCKS  = 24'h001000;
    localparam int          STATUS_SB_BIT    = 1;
    localparam int          STATUS_PD_BIT    = 0;
    localparam logic [7:0]  READ_DEFAULT     = 8'h00;
    // ****************************************
    // Readout byte phase
    // ****************************************
    typedef enum logic [1:0] {
        UVR_IDLE = 2'b00,
        UVR_LOW  = 2'b01,
        UVR_HIGH = 2'b11
    } uvr_phase_t;
endpackage : uvr_pkg

// ### hw/uvr_sat.sv
// Saturating narrowing of a wide measurement count.
// Assumes an unsigned count from the measurement engine.
module uvr_sat
    import uvr_pkg::*;
#(
    parameter int IN_W = 24
) (
    input  wire logic [IN_W-1:0] in_count,
    output logic      [15:0]     out_value
);
    // ****************************************
    // Clamp at all-ones
    // ****************************************
    wire over = |in_count[IN_W-1:16];
    assign out_value = over ? RESULT_MAX : in_count[15:0];
endmodule : uvr_sat

// ### hw/uvr_readback.sv
// Output register bank for sensor results, read byte by byte.
// Assumes the I2C front end gives start, stop, read strobe and address
// on CLK; standby and power-down controls are live internal levels.
module uvr_readback
    import uvr_pkg::*;
#(
    parameter int MEAS_W = 24
) (
    input  wire logic                 CLK,
    input  wire logic                 RST,
    input  wire logic                 SOFT_RESET,
    input  wire logic                 CONFIG_STATE,
    input  wire logic                 STANDBY_CTRL,
    input  wire logic                 POWER_DOWN_CTRL,
    input  wire logic                 EXT_SYNC_START_STOP_MODE,
    input  wire logic                 CONV_TIME_COUNTER_ENABLE,
    input  wire logic                 MEAS_DONE,
    input  wire logic [TEMP_BITS-1:0] MEAS_TEMP,
    input  wire logic [MEAS_W-1:0]    MEAS_CH1,
    input  wire logic [MEAS_W-1:0]    MEAS_CH2,
    input  wire logic [MEAS_W-1:0]    MEAS_CH3,
    input  wire logic [CONV_BITS-1:0] CONVERSION_TIME_COUNT,
    input  wire logic                 BUS_START,
    input  wire logic                 BUS_STOP,
    input  wire logic                 BUS_READ,
    input  wire logic                 BUS_WRITE,
    input  wire logic [7:0]           BUS_ADDR,
    output logic      [7:0]           BUS_RDATA,
    output logic                      TEMP_VALID
);
    // ****************************************
    // Buffers and output bank
    // ****************************************
    logic [15:0] buf_res [0:4];
    logic [15:0] out_res [0:4];
    logic        buf_tvalid;
    logic        in_read;
    uvr_phase_t  phase;
    logic [7:0]  last_addr;
    logic [15:0] sat1;
    logic [15:0] sat2;
    logic [15:0] sat3;
    logic [15:0] sat_conv;

    uvr_sat #(.IN_W(MEAS_W)) u_sat1 (.in_count(MEAS_CH1), .out_value(sat1));
    uvr_sat #(.IN_W(MEAS_W)) u_sat2 (.in_count(MEAS_CH2), .out_value(sat2));
    uvr_sat #(.IN_W(MEAS_W)) u_sat3 (.in_count(MEAS_CH3), .out_value(sat3));
    uvr_sat #(.IN_W(CONV_BITS)) u_satc (.in_count(CONVERSION_TIME_COUNT),
                                        .out_value(sat_conv));

    wire clear_bank = SOFT_RESET | CONFIG_STATE;
    wire sync_no_temp = EXT_SYNC_START_STOP_MODE & ~CONV_TIME_COUNTER_ENABLE;
    wire sync_short = EXT_SYNC_START_STOP_MODE & CONV_TIME_COUNTER_ENABLE
                    & (CONVERSION_TIME_COUNT < TEMP_MIN_CLOCKS);
    wire temp_ok = ~sync_no_temp & ~sync_short;
    wire [15:0] temp_word = sync_no_temp ? RESULT_RESET
                                         : {TEMP_PAD, MEAS_TEMP};
    wire transfer = BUS_START & ~in_read;
    logic [7:0] status_byte;
    always_comb begin
        status_byte                = READ_DEFAULT;
        status_byte[STATUS_SB_BIT] = STANDBY_CTRL;
        status_byte[STATUS_PD_BIT] = POWER_DOWN_CTRL;
    end
    wire new_addr = BUS_ADDR != last_addr;

    function automatic int unsigned slot(input logic [7:0] a);
        slot = 32'(a - ADDR_TEMP);
    endfunction : slot

    wire addr_hit = (BUS_ADDR >= ADDR_TEMP) && (BUS_ADDR <= ADDR_CONV);
    wire [15:0] sel_word = addr_hit ? out_res[slot(BUS_ADDR)] : RESULT_RESET;

    // ****************************************
    // Capture measurements into buffers
    // ****************************************
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < 5; i++) begin
                buf_res[i] <= RESULT_RESET;
            end
            buf_tvalid <= 1'b0;
        end else if (clear_bank) begin
            for (int i = 0; i < 5; i++) begin
                buf_res[i] <= RESULT_RESET;
            end
            buf_tvalid <= 1'b0;
        end else if (MEAS_DONE) begin
            buf_res[0] <= temp_word;
            buf_res[1] <= sat1;
            buf_res[2] <= sat2;
            buf_res[3] <= sat3;
            buf_res[4] <= sat_conv;
            buf_tvalid <= temp_ok;
        end
    end

    // ****************************************
    // Output bank, frozen during a read
    // ****************************************
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < 5; i++) begin
                out_res[i] <= RESULT_RESET;
            end
            TEMP_VALID <= 1'b0;
            in_read    <= 1'b0;
        end else if (clear_bank) begin
            for (int i = 0; i < 5; i++) begin
                out_res[i] <= RESULT_RESET;
            end
            TEMP_VALID <= 1'b0;
            in_read    <= 1'b0;
        end else begin
            if (transfer) begin
                for (int i = 0; i < 5; i++) begin
                    out_res[i] <= buf_res[i];
                end
                TEMP_VALID <= buf_tvalid;
            end
            if (BUS_STOP) begin
                in_read <= 1'b0;
            end else if (BUS_START) begin
                in_read <= 1'b1;
            end
        end
    end

    // ****************************************
    // Byte readout, low byte first
    // ****************************************
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            phase     <= UVR_IDLE;
            last_addr <= READ_DEFAULT;
            BUS_RDATA <= READ_DEFAULT;
        end else if (BUS_START | BUS_STOP | clear_bank) begin
            phase     <= UVR_IDLE;
            last_addr <= READ_DEFAULT;
            BUS_RDATA <= READ_DEFAULT;
        end else if (BUS_READ) begin
            last_addr <= BUS_ADDR;
            if (BUS_ADDR == ADDR_STATUS) begin
                BUS_RDATA <= status_byte;
                phase     <= UVR_IDLE;
            end else if (!addr_hit) begin
                BUS_RDATA <= READ_DEFAULT;
                phase     <= UVR_IDLE;
            end else if (phase == UVR_LOW && !new_addr) begin
                BUS_RDATA <= sel_word[15:8];
                phase     <= UVR_HIGH;
            end else begin
                BUS_RDATA <= sel_word[7:0];
                phase     <= UVR_LOW;
            end
        end
        // Writes to result addresses change nothing here
    end

    wire unused_write = BUS_WRITE;
endmodule : uvr_readback

// ### bench/uvr_assertions.sv
// Checker for the result readback bank.
// Assumes binding to uvr_readback and sight of its ports only.
module uvr_assertions
    import uvr_pkg::*;
(
    input wire logic       CLK, RST, SOFT_RESET, CONFIG_STATE, STANDBY_CTRL, POWER_DOWN_CTRL,
    input wire logic       EXT_SYNC_START_STOP_MODE, CONV_TIME_COUNTER_ENABLE, TEMP_VALID,
    input wire logic       BUS_START, BUS_STOP, BUS_READ, MEAS_DONE,
    input wire logic [7:0] BUS_ADDR, BUS_RDATA
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    AST_STATUS_LIVE: assert property (BUS_READ && BUS_ADDR == ADDR_STATUS |=>
        BUS_RDATA[1:0] == {$past(STANDBY_CTRL), $past(POWER_DOWN_CTRL)}) else $error("status");
    AST_TEMP_HIGH: assert property (BUS_READ && $past(BUS_READ) && !$past(BUS_READ, 2) &&
        BUS_ADDR == ADDR_TEMP && $past(BUS_ADDR) == ADDR_TEMP |=> BUS_RDATA[7:4] == TEMP_PAD)
        else $error("temp high nibble");
    AST_UNMAPPED: assert property (BUS_READ && BUS_ADDR > ADDR_CONV |=>
        BUS_RDATA == READ_DEFAULT) else $error("unmapped read");
    AST_SOFT_CLR: assert property (SOFT_RESET ##3 BUS_READ && BUS_ADDR == ADDR_TEMP |=>
        BUS_RDATA == RESULT_RESET[7:0]) else $error("soft clear");
    AST_CONFIG_CLR: assert property (CONFIG_STATE ##3 BUS_READ && BUS_ADDR == ADDR_TEMP |=>
        BUS_RDATA == RESULT_RESET[7:0]) else $error("config clear");
    AST_FRAME_CLR: assert property ((BUS_START || BUS_STOP) && !BUS_READ |=>
        BUS_RDATA == READ_DEFAULT) else $error("frame clear");
    AST_HOLD: assert property (!(BUS_READ || BUS_START || BUS_STOP || SOFT_RESET ||
        CONFIG_STATE) |=> $stable(BUS_RDATA)) else $error("read data moved");
    AST_VALID_OFF: assert property (EXT_SYNC_START_STOP_MODE && !CONV_TIME_COUNTER_ENABLE
        && MEAS_DONE ##2 BUS_START && !$past(BUS_START) |=> !TEMP_VALID)
        else $error("valid with counter off");
endmodule : uvr_assertions

bind uvr_readback uvr_assertions u_chk (.*);

// ### bench/uvr_host.sv
// Host model issuing register reads and writes to the readback bank.
// Assumes a free-running CLK; outputs change at the falling edge.
module uvr_host (
    input  wire logic       CLK,
    output logic            BUS_START, BUS_STOP, BUS_READ, BUS_WRITE,
    output logic      [7:0] BUS_ADDR
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {BUS_START, BUS_STOP, BUS_READ, BUS_WRITE, BUS_ADDR} = 12'h000;
    end
    task automatic op(input logic [3:0] s, input logic [7:0] a);
        @(negedge CLK);
        {BUS_START, BUS_STOP, BUS_READ, BUS_WRITE} = s;
        BUS_ADDR = a;
    endtask : op
    // Start, n byte accesses, stop; a word comes low byte then high
    task automatic xfer(input logic [7:0] a, input int n, input logic wr);
        op(4'h8, a);
        for (int i = 0; i < n; i++) begin
            op(wr ? 4'h1 : 4'h2, a);
        end
        op(4'h4, a);
        op(4'h0, ~a);
    endtask : xfer
endmodule : uvr_host

// ### bench/uvr_readback_tb.sv
// Self-checking bench for the result readback bank.
// Assumes the host model and the bound checker are compiled first.
module uvr_readback_tb
    import uvr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        CLK, RST, SOFT_RESET, CONFIG_STATE, STANDBY_CTRL, POWER_DOWN_CTRL, rd_d;
    logic        EXT_SYNC_START_STOP_MODE, CONV_TIME_COUNTER_ENABLE, MEAS_DONE, TEMP_VALID;
    logic        BUS_START, BUS_STOP, BUS_READ, BUS_WRITE;
    logic [11:0] MEAS_TEMP, t;
    logic [23:0] MEAS_CH1, CONVERSION_TIME_COUNT, c;
    logic [7:0]  BUS_ADDR, BUS_RDATA;
    logic [15:0] exp_q[$];
    logic [15:0] e;
    int          fails, comparisons;
    uvr_readback dut (.*, .MEAS_CH2(~MEAS_CH1), .MEAS_CH3(MEAS_CH1));
    uvr_host host (.*);
    initial begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] want);
        comparisons++;
        if (got !== want) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, want);
        end
    endtask : chk
    task automatic print_verdict;
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict
    task automatic meas(input logic [11:0] tv, input logic [23:0] cv, input logic [23:0] n);
        @(negedge CLK);
        {MEAS_TEMP, MEAS_CH1, CONVERSION_TIME_COUNT, MEAS_DONE} = {tv, cv, n, 1'b1};
        @(negedge CLK);
        MEAS_DONE = 1'b0;
    endtask : meas
    task automatic expw(input logic [15:0] v);
        exp_q.push_back({8'hFF, v[7:0]});
        exp_q.push_back({8'hFF, v[15:8]});
    endtask : expw
    // Byte answer lands one cycle after its read; notes are {mask, value}
    always @(posedge CLK) rd_d <= BUS_READ;
    always @(negedge CLK) if (rd_d) begin
        e = exp_q.pop_front();
        chk(BUS_RDATA & e[15:8], e[7:0]);
    end
    initial begin
        #100us;
        fails++;
        print_verdict();
    end
    initial begin
        {RST, SOFT_RESET, CONFIG_STATE, MEAS_DONE, rd_d, STANDBY_CTRL, POWER_DOWN_CTRL} = 7'h40;
        {EXT_SYNC_START_STOP_MODE, CONV_TIME_COUNTER_ENABLE} = 2'b00;
        {MEAS_TEMP, MEAS_CH1, CONVERSION_TIME_COUNT} = 60'h0;
        fails = 0;
        comparisons = 0;
        void'($urandom(68392));
        repeat (4) @(negedge CLK);
        RST = 1'b0;
        expw(RESULT_RESET);
        host.xfer(ADDR_TEMP, 2, 1'b0);
        for (int i = 0; i < 6; i++) begin
            t = 12'($urandom);
            c = i[0] ? 24'($urandom) : 24'($urandom) & 24'h00FFFF;
            {STANDBY_CTRL, POWER_DOWN_CTRL} = i[1:0];
            meas(t, c, 24'h001000);
            expw({4'h0, t});
            host.xfer(ADDR_TEMP, 2, 1'b0);
            expw(c > 24'h00FFFF ? RESULT_MAX : c[15:0]);
            host.xfer(ADDR_MRES1, 2, 1'b0);
            exp_q.push_back({8'h03, 6'h0, i[1:0]});
            host.xfer(ADDR_STATUS, 1, 1'b0);
            exp_q.push_back({8'hFF, READ_DEFAULT});
            host.xfer(8'h06 + c[7:0] % 8'hFA, 1, 1'b0);
        end
        meas(12'h123, 24'h0, 24'h001000);
        expw(16'h0123);
        fork
            host.xfer(ADDR_TEMP, 2, 1'b0);
            begin
                @(negedge CLK);
                meas(12'h456, 24'h0, 24'h001000);
            end
        join
        host.xfer(ADDR_TEMP, 1, 1'b1);
        expw(16'h0456);
        host.xfer(ADDR_TEMP, 2, 1'b0);
        for (int k = 0; k < 2; k++) begin
            @(negedge CLK);
            {SOFT_RESET, CONFIG_STATE} = k ? 2'b01 : 2'b10;
            @(negedge CLK);
            {SOFT_RESET, CONFIG_STATE} = 2'b00;
            expw(RESULT_RESET);
            host.xfer(ADDR_TEMP, 2, 1'b0);
        end
        for (int k = 0; k < 4; k++) begin
            {EXT_SYNC_START_STOP_MODE, CONV_TIME_COUNTER_ENABLE} = {k != 3, k != 0};
            meas(12'h0AB, 24'h0, k == 1 ? 24'h000FFF : k == 3 ? 24'h000010 : TEMP_MIN_CLOCKS);
            expw(k == 0 ? RESULT_RESET : 16'h00AB);
            host.xfer(ADDR_TEMP, 2, 1'b0);
            chk({7'h0, TEMP_VALID}, {7'h0, k > 1});
        end
        repeat (2) @(negedge CLK);
        print_verdict();
    end
endmodule : uvr_readback_tb
